// ### hdl/clk_sel_pkg.sv
// package for the sample clock source selector: register map, field layout,
// reset values, source codes, rate tables and timing counts.
// assumes a 250 MHz system clock and an APB register bus with 32-bit data.
package clk_sel_pkg;

  // system clock and measurement gate
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned GATE_TIME_MS = 1;          // frequency meter gate time
  localparam int unsigned GATE_CYCLES  = CLK_HZ / 1000 * GATE_TIME_MS;

  // accepted input rate window and derived limits in Hz, and madi channel counts
  localparam logic [17:0] RATE_MIN_HZ     = 18'd28000;
  localparam logic [17:0] RATE_MAX_HZ     = 18'd200000;
  localparam logic [17:0] SINGLE_MAX_HZ   = 18'd48000;   // above this madi halves its channels
  localparam logic [17:0] DEFAULT_RATE_HZ = 18'd48000;
  localparam logic [17:0] SYNC_TOL_HZ     = 18'd50;
  localparam logic [6:0]  MADI_CH_FULL    = 7'd64;
  localparam logic [6:0]  MADI_CH_HALF    = 7'd32;

  // phase step per Hz for a 48-bit accumulator: 2^48 / CLK_HZ, rounded
  localparam longint unsigned DDS_K_L = ((64'd1 << 48) + CLK_HZ / 2) / CLK_HZ;
  localparam logic [20:0] DDS_K = 21'(DDS_K_L);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SYNTH  = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FREQ   = 8'h10;
  localparam logic [7:0] OFS_RATE   = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST = 8'h18;
  localparam logic [7:0] OFS_IRQ_MK = 8'h1C;

  // field positions
  localparam int CTRL_AUTO = 0;   // 1: automatic selection, 0: internal master
  localparam int CTRL_PREF = 1;   // [2:1] preferred source index
  localparam int CTRL_WCR  = 4;   // [6:4] word clock ratio code
  localparam int SYN_EN    = 0;
  localparam int SYN_BASE  = 1;   // [2:1]
  localparam int SYN_MULT  = 3;   // [4:3]
  localparam int SYN_CACT  = 5;
  localparam int SYN_FACT  = 6;
  localparam int OFS_COARSE = 0;  // [15:0] signed Hz
  localparam int OFS_FINE   = 16; // [23:16] signed Hz
  localparam int IRQ_CHG   = 0;   // active source changed
  localparam int IRQ_FALL  = 1;   // fell back to internal clock
  localparam int IRQ_LOST  = 2;   // an input lost its signal

  // reset values
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [6:0]  SYNTH_RST  = 7'h04;   // disabled, base 48 kHz, single speed
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [2:0]  IRQ_MK_RST = 3'h0;

  // word clock ratio codes
  localparam logic [2:0] WCR_X1 = 3'h0;
  localparam logic [2:0] WCR_D2 = 3'h1;
  localparam logic [2:0] WCR_D4 = 3'h2;
  localparam logic [2:0] WCR_M2 = 3'h3;
  localparam logic [2:0] WCR_M4 = 3'h4;

  // lock and sync report codes
  localparam logic [1:0] LS_NONE = 2'h0;
  localparam logic [1:0] LS_LOCK = 2'h1;
  localparam logic [1:0] LS_SYNC = 2'h2;

  // clock sources, gray coded along word clock, madi, video, timecode, internal
  typedef enum logic [2:0] {
    SRC_WC    = 3'h0,
    SRC_MADI  = 3'h1,
    SRC_VIDEO = 3'h3,
    SRC_LTC   = 3'h2,
    SRC_INT   = 3'h6
  } src_t;

endpackage : clk_sel_pkg

// ### hdl/freq_meter.sv
// frequency meter: counts one-cycle sample ticks over a fixed gate and
// reports the rate in Hz, refreshed at the end of every gate.
// assumes the tick input is synchronous to clk and one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module freq_meter
  import clk_sel_pkg::*;
#(
  parameter int unsigned GATE = GATE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  output logic [17:0]      freq_hz_q
);
  localparam int unsigned SCALE = CLK_HZ / GATE;   // ticks per gate to Hz

  logic [31:0] gate_q;
  logic [17:0] cnt_q;
  wire         gate_end = (gate_q == 32'(GATE - 1));
  wire  [31:0] scaled   = 32'(cnt_q) * 32'(SCALE);

  // a short gate in simulation keeps reporting Hz through the scale factor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q    <= 32'h0;
      cnt_q     <= 18'h0;
      freq_hz_q <= 18'h0;
    end else begin
      gate_q    <= gate_end ? 32'h0 : gate_q + 32'h1;
      cnt_q     <= gate_end ? 18'(tick) : cnt_q + 18'(tick);
      if (gate_end) freq_hz_q <= (scaled[31:18] != 14'h0) ? 18'h3FFFF : scaled[17:0];
    end
  end

endmodule : freq_meter
`default_nettype wire

// ### hdl/clk_source_select.sv
// sample clock source selector with rate synthesizer and lock reporting.
// assumes source ticks and lock levels are synchronous to clk, APB master.
//
// Contract
// - automatic mode takes the first input with a valid signal as reference
// - preferred input used while valid, else other inputs scanned in turn
// - no valid input at all falls back to internal master clock
// - inputs between 28 kHz and 200 kHz are accepted and locked
// - output follows word clock at equal, half, quarter, double, quad rate
// - each input reports no signal, locked, or locked and synchronous
// - current sync source and its measured frequency are reported
// - synthesized rate applies only in internal master mode, this card only; the code also applies it when automatic mode falls back to internal
// - synthesizer enable activates all synthesized settings, off means no effect
// - synthesized rate is base times multiplier plus active offset
// - multiplier gives single, double or quad speed
// - coarse and fine offsets, each activated separately, step 1 Hz
// - madi above single speed carries only channels 1 to 32
// - clock mode picks internal master or automatic preferred selection
// - video and timecode sources join only with timecode option fitted
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module clk_source_select
  import clk_sel_pkg::*;
#(
  parameter int unsigned GATE = GATE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  src_tick,
  input  wire logic [3:0]  src_lock,
  input  wire logic        timecode_option_fitted,
  output logic             sample_tick,
  output logic             madi_half_channels,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [17:0] f);
    return (f >= RATE_MIN_HZ) && (f <= RATE_MAX_HZ);
  endfunction : in_range

  function automatic src_t idx2src(input logic [1:0] i);
    unique case (i)
      2'd0: return SRC_WC;
      2'd1: return SRC_MADI;
      2'd2: return SRC_VIDEO;
      2'd3: return SRC_LTC;
    endcase
  endfunction : idx2src

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [6:0]  ctrl_q;
  logic [6:0]  synth_q;
  logic [23:0] offset_q;
  logic [2:0]  irq_st_q, irq_mk_q;
  src_t        sel_q;
  logic [17:0] synth_rate_q, active_freq_q;
  logic [38:0] incr_q;
  logic [47:0] acc_q;
  logic        synth_tick_q, sample_tick_q, madi_half_q;
  logic [3:0]  avail_q;
  logic [1:0]  div_q, sub_left_q;
  logic [23:0] per_cnt_q, per_q, sub_cnt_q;
  logic [31:0] prdata_q;
  logic [17:0] freq [4];

  // one meter per input
  for (genvar g = 0; g < 4; g++) begin : g_meter
    freq_meter #(.GATE(GATE)) u_meter (
      .clk       (clk),
      .rst_n     (rst_n),
      .tick      (src_tick[g]),
      .freq_hz_q (freq[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // availability and selection

  wire       auto_mode = ctrl_q[CTRL_AUTO];
  wire [1:0] pref      = ctrl_q[CTRL_PREF +: 2];
  wire [2:0] wc_ratio  = ctrl_q[CTRL_WCR +: 3];
  wire       opt_ok    = timecode_option_fitted;
  // an input counts only when locked and inside the accepted window
  wire [3:0] avail = {src_lock[3] & in_range(freq[3]) & opt_ok,
                      src_lock[2] & in_range(freq[2]) & opt_ok,
                      src_lock[1] & in_range(freq[1]),
                      src_lock[0] & in_range(freq[0])};

  src_t pick;
  // preferred first, then fixed priority 0..3 skipping it, else internal
  always_comb begin
    pick = SRC_INT;
    if (auto_mode) begin
      if (avail[pref]) begin
        pick = idx2src(pref);
      end else begin
        for (int i = 3; i >= 0; i--) begin
          if (avail[i] && (2'(i) != pref)) pick = idx2src(2'(i));
        end
      end
    end
  end

  // switch only between ticks so no pulse is cut or doubled
  wire switch_ok = ~|src_tick & ~synth_tick_q;

  ////////////////////////////////////////////////////////////////////////////
  // rate synthesizer

  wire        syn_en = synth_q[SYN_EN];
  wire [1:0]  base_c = synth_q[SYN_BASE +: 2];
  wire [1:0]  mult_c = synth_q[SYN_MULT +: 2];
  wire [17:0] base_hz = (base_c == 2'd0) ? 18'd32000 : (base_c == 2'd1) ? 18'd44100
                                                                     : 18'd48000;
  wire [17:0] speed_hz = (mult_c == 2'd1) ? {base_hz[16:0], 1'b0}
                       : (mult_c == 2'd2) ? {base_hz[15:0], 2'b0} : base_hz;
  wire signed [18:0] coarse = synth_q[SYN_CACT] ? 19'(signed'(offset_q[OFS_COARSE +: 16]))
                                                : 19'sd0;
  wire signed [18:0] fine   = synth_q[SYN_FACT] ? 19'(signed'(offset_q[OFS_FINE +: 8]))
                                                : 19'sd0;
  wire signed [20:0] raw    = 21'(signed'({1'b0, speed_hz})) + 21'(coarse) + 21'(fine);
  wire [17:0] clamped = (raw < 21'(signed'({1'b0, RATE_MIN_HZ}))) ? RATE_MIN_HZ
                      : (raw > 21'(signed'({1'b0, RATE_MAX_HZ}))) ? RATE_MAX_HZ : raw[17:0];
  wire [17:0] rate_d  = syn_en ? clamped : DEFAULT_RATE_HZ;
  wire [48:0] acc_sum = {1'b0, acc_q} + {10'h0, incr_q};

  // phase accumulator; its carry is the internal sample tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_rate_q <= DEFAULT_RATE_HZ;
      incr_q       <= 39'h0;
      acc_q        <= 48'h0;
      synth_tick_q <= 1'b0;
    end else begin
      synth_rate_q <= rate_d;
      incr_q       <= 39'(synth_rate_q) * 39'(DDS_K);
      acc_q        <= acc_sum[47:0];
      synth_tick_q <= acc_sum[48];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word clock ratio: divide by counting, multiply by splitting the period

  wire        wc     = src_tick[0];
  wire        mul    = (wc_ratio == WCR_M2) || (wc_ratio == WCR_M4);
  wire [23:0] sub_ld = (wc_ratio == WCR_M4) ? (per_q >> 2) : (per_q >> 1);
  wire        sub_hit = (sub_left_q != 2'd0) && (sub_cnt_q == 24'h1);
  wire        wc_out  = (wc_ratio == WCR_D2) ? (wc & ~div_q[0])
                      : (wc_ratio == WCR_D4) ? (wc & (div_q == 2'd0))
                      : mul ? (wc | sub_hit) : wc;

  // period of the last word clock cycle feeds the in-between ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
      per_cnt_q <= 24'h0;
      per_q <= 24'h0;
      sub_cnt_q <= 24'h0;
      sub_left_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'(wc);
      per_cnt_q <= wc ? 24'h1 : per_cnt_q + 24'h1;
      if (wc) per_q <= per_cnt_q;
      if (wc && mul) begin
        sub_cnt_q <= sub_ld;
        sub_left_q <= (wc_ratio == WCR_M4) ? 2'd3 : 2'd1;
      end else if (sub_hit) begin
        sub_cnt_q <= sub_ld;
        sub_left_q <= sub_left_q - 2'd1;
      end else if (sub_cnt_q != 24'h0) begin
        sub_cnt_q <= sub_cnt_q - 24'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output tick, reported rate and madi width

  logic tick_mux;
  logic [17:0] cur_rate;
  // synthesized rate reaches the output only with the internal source
  always_comb begin
    unique case (sel_q)
      SRC_INT:   tick_mux = synth_tick_q;
      SRC_WC:    tick_mux = wc_out;
      SRC_MADI:  tick_mux = src_tick[1];
      SRC_VIDEO: tick_mux = src_tick[2];
      SRC_LTC:   tick_mux = src_tick[3];
      default:   tick_mux = synth_tick_q;
    endcase
  end

  wire [17:0] wc_rate = (wc_ratio == WCR_D2) ? (freq[0] >> 1)
                      : (wc_ratio == WCR_D4) ? (freq[0] >> 2)
                      : (wc_ratio == WCR_M2) ? {freq[0][16:0], 1'b0}
                      : (wc_ratio == WCR_M4) ? {freq[0][15:0], 2'b0} : freq[0];
  always_comb begin
    unique case (sel_q)
      SRC_WC:    cur_rate = wc_rate;
      SRC_MADI:  cur_rate = freq[1];
      SRC_VIDEO: cur_rate = freq[2];
      SRC_LTC:   cur_rate = freq[3];
      default:   cur_rate = synth_rate_q;
    endcase
  end

  // lock state per input: synchronous when it matches the running rate
  logic [7:0] lock_state;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!avail_q[i])
        lock_state[2*i +: 2] = LS_NONE;
      else if (((freq[i] > active_freq_q) ? freq[i] - active_freq_q
                                          : active_freq_q - freq[i]) <= SYNC_TOL_HZ)
        lock_state[2*i +: 2] = LS_SYNC;
      else
        lock_state[2*i +: 2] = LS_LOCK;
    end
  end

  wire [2:0] ev = {|(avail_q & ~avail),
                   switch_ok && (pick != sel_q) && (pick == SRC_INT) && auto_mode,
                   switch_ok && (pick != sel_q)};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SRC_INT;
      avail_q <= 4'h0;
      sample_tick_q <= 1'b0;
      active_freq_q <= 18'h0;
      madi_half_q <= 1'b0;
    end else begin
      if (switch_ok) sel_q <= pick;
      avail_q <= avail;
      sample_tick_q <= tick_mux;
      active_freq_q <= cur_rate;
      madi_half_q <= (cur_rate > SINGLE_MAX_HZ);
    end
  end

  assign sample_tick = sample_tick_q;
  assign madi_half_channels = madi_half_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle

  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire hit    = (paddr[1:0] == 2'b00) && (paddr <= OFS_IRQ_MK);
  wire wr     = access & pwrite & hit;
  wire [31:0] rd_mux =
      (paddr == OFS_CTRL)   ? {25'h0, ctrl_q}
    : (paddr == OFS_SYNTH)  ? {25'h0, synth_q}
    : (paddr == OFS_OFFSET) ? {8'h0, offset_q}
    : (paddr == OFS_STATUS) ? {13'h0, (madi_half_q ? MADI_CH_HALF : MADI_CH_FULL),
                               lock_state, 1'b0, 3'(sel_q)}
    : (paddr == OFS_FREQ)   ? {14'h0, active_freq_q}
    : (paddr == OFS_RATE)   ? {14'h0, synth_rate_q}
    : (paddr == OFS_IRQ_ST) ? {29'h0, irq_st_q}
    : (paddr == OFS_IRQ_MK) ? {29'h0, irq_mk_q} : 32'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      synth_q <= SYNTH_RST;
      offset_q <= OFFSET_RST;
      irq_mk_q <= IRQ_MK_RST;
      irq_st_q <= 3'h0;
      prdata_q <= 32'h0;
    end else begin
      if (setup) prdata_q <= rd_mux;
      if (wr && paddr == OFS_CTRL) ctrl_q <= pwdata[6:0];
      if (wr && paddr == OFS_SYNTH) synth_q <= pwdata[6:0];
      if (wr && paddr == OFS_OFFSET) offset_q <= pwdata[23:0];
      if (wr && paddr == OFS_IRQ_MK) irq_mk_q <= pwdata[2:0];
      // a new event wins over a write-one clear in the same cycle
      irq_st_q <= (irq_st_q & ~((wr && paddr == OFS_IRQ_ST) ? pwdata[2:0] : 3'h0)) | ev;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign irq     = |(irq_st_q & irq_mk_q);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_master_internal: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_mode [*2] |-> ##[0:8] (sel_q == SRC_INT))
    else $error("master mode did not select internal clock");
  a_fallback_int: assert property (@(posedge clk) disable iff (!rst_n)
    (avail == 4'h0) [*8] |-> (sel_q == SRC_INT) || !switch_ok)
    else $error("no valid input but external source still selected");
  a_pref_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (auto_mode && avail[pref] && switch_ok) |=> (sel_q == idx2src($past(pref))))
    else $error("preferred valid input not taken");
  a_avail_range: assert property (@(posedge clk) disable iff (!rst_n)
    avail[1] |-> (freq[1] >= RATE_MIN_HZ && freq[1] <= RATE_MAX_HZ))
    else $error("madi accepted outside rate window");
  a_option_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !timecode_option_fitted |=> (sel_q != SRC_VIDEO) && (sel_q != SRC_LTC) || !$past(switch_ok))
    else $error("optional source used without option");
  a_synth_off: assert property (@(posedge clk) disable iff (!rst_n)
    !syn_en [*2] |-> (synth_rate_q == DEFAULT_RATE_HZ))
    else $error("synth settings active while disabled");
  a_switch_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q != $past(sel_q)) |-> $past(switch_ok))
    else $error("source switched on a tick");
  a_madi_half: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_rate > SINGLE_MAX_HZ) |=> madi_half_q)
    else $error("madi not halved above single speed");
  a_report_freq: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q == SRC_MADI) [*2] |-> (active_freq_q == $past(freq[1])))
    else $error("reported frequency does not follow source");

  c_fallback: cover property (@(posedge clk) disable iff (!rst_n) ev[IRQ_FALL]);
  c_wc_double: cover property (@(posedge clk) disable iff (!rst_n)
    (sel_q == SRC_WC) && (wc_ratio == WCR_M2) && sub_hit);
  c_synth_on: cover property (@(posedge clk) disable iff (!rst_n)
    (sel_q == SRC_INT) && syn_en && synth_tick_q);

endmodule : clk_source_select
`default_nettype wire

// ### verif/src_model.sv
// external source model: sample ticks and carrier lock per clock input.
// assumes the bench enables each input; a dead input neither ticks nor locks.
`timescale 1ns/1ps
`default_nettype none
module src_model #(
  parameter int PER_LO = 5000,
  parameter int PER_HI = 2500
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] on,
  output logic      [3:0] src_tick,
  output logic      [3:0] src_lock
);
  int cnt [4];
  // lock follows the carrier; a removed cable drops it at once
  assign src_lock = on;
  // word clock and timecode at 50 kHz, madi and video at 100 kHz, inside 28k..200k
  always @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n || !on[i]) begin
        cnt[i]      <= 0;
        src_tick[i] <= 1'b0;
      end else begin
        cnt[i]      <= (cnt[i] == ((i % 3 == 0) ? PER_LO : PER_HI) - 1) ? 0 : cnt[i] + 1;
        src_tick[i] <= (cnt[i] == 0);
      end
    end
  end
endmodule : src_model
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the sample clock source selector.
// assumes a short meter gate so rates are exact multiples of 50 kHz.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import clk_sel_pkg::*;
  localparam int unsigned GATE = 5000;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, sample_tick, madi_half_channels, irq;
  logic [3:0]  on = 4'h0, src_tick, src_lock;
  int          n_fail = 0, check_count = 0, cyc = 0;

  clk_source_select #(.GATE(GATE)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_tick(src_tick), .src_lock(src_lock),
    .timecode_option_fitted(1'b0), .sample_tick(sample_tick),
    .madi_half_channels(madi_half_channels), .irq(irq));
  src_model src_u (.clk(clk), .rst_n(rst_n), .on(on), .src_tick(src_tick), .src_lock(src_lock));

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and a hang limit well above the planned run
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end

  // one apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk_rd

  ////////////////////////////////////////////////////////////////////////////
  // reset state: master mode, synth off at 48 kHz, unmapped address refused
  task automatic t_reset;
    chk_rd(OFS_CTRL, 32'h0000_0000);
    chk_rd(OFS_SYNTH, 32'h0000_0004);
    chk_rd(OFS_RATE, 32'd48000);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], SRC_INT)
    `CHK(rd[18:12], MADI_CH_FULL)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    `CHK(irq, 1'b0)
  endtask : t_reset

  // synthesized rate: base times multiplier plus each activated offset
  task automatic t_synth;
    int n_tick;
    apb(1'b1, OFS_OFFSET, 32'h00FB_0064); // coarse +100 Hz, fine -5 Hz
    apb(1'b1, OFS_SYNTH, 32'h0000_002B); // 44.1k, double speed, coarse only
    chk_rd(OFS_RATE, 32'd88300);
    apb(1'b1, OFS_SYNTH, 32'h0000_006B);
    chk_rd(OFS_RATE, 32'd88295);
    for (int i = 0; i < 1000 && madi_half_channels !== 1'b1; i++) @(negedge clk);
    `CHK(madi_half_channels, 1'b1)
    apb(1'b1, OFS_SYNTH, 32'h0000_0011); // 32k quad speed
    chk_rd(OFS_RATE, 32'd128000);
    // 128 kHz is one tick per 1953.125 clocks, so 5 or 6 in 10000 clocks
    n_tick = 0;
    repeat (10000) begin
      @(negedge clk);
      n_tick += int'(sample_tick);
    end
    `CHK((n_tick == 5) || (n_tick == 6), 1'b1)
    apb(1'b1, OFS_SYNTH, 32'h0000_0070); // 32k quad, both offsets active, enable clear
    chk_rd(OFS_RATE, 32'd48000);
    `CHK(madi_half_channels, 1'b0)
    apb(1'b1, OFS_SYNTH, 32'h0000_0004);
  endtask : t_synth

  // automatic mode with madi preferred; report, tick path and interrupt
  task automatic t_auto;
    on <= 4'h7; // video lives but the timecode option is absent
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    repeat (3 * GATE) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], SRC_MADI)
    `CHK(rd[9:4], {LS_NONE, LS_SYNC, LS_LOCK})
    `CHK(rd[18:12], MADI_CH_HALF)
    chk_rd(OFS_FREQ, 32'd100000);
    `CHK(madi_half_channels, 1'b1)
    // look between edges so the source tick and its delayed copy are settled
    @(negedge clk);
    for (int i = 0; i < 3000 && src_tick[1] !== 1'b1; i++) @(negedge clk);
    `CHK(sample_tick, 1'b0)
    @(negedge clk);
    `CHK(sample_tick, 1'b1)
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    `CHK({irq, rd[IRQ_CHG]}, 2'b01)
    apb(1'b1, OFS_IRQ_MK, 32'h0000_0001);
    @(negedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, OFS_IRQ_ST, 32'h0000_0007);
    @(negedge clk);
    `CHK(irq, 1'b0)
  endtask : t_auto

  // preferred input lost: lowest valid input next, then master fallback
  task automatic t_fallback;
    on <= 4'h5;
    repeat (GATE) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], SRC_WC)
    chk_rd(OFS_FREQ, 32'd50000);
    // word clock ratio: double, then half of the 50 kHz input
    apb(1'b1, OFS_CTRL, 32'h0000_0033);
    chk_rd(OFS_FREQ, 32'd100000);
    apb(1'b1, OFS_CTRL, 32'h0000_0013);
    chk_rd(OFS_FREQ, 32'd25000);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    on <= 4'h4;
    repeat (GATE) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], SRC_INT)
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    `CHK(rd[2:1], 2'b11)
  endtask : t_fallback

  // single verdict point for the normal end and the hang limit
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_synth();
    t_auto();
    t_fallback();
    complete_run();
  end
endmodule : tb
`default_nettype wire
